// ---- core/power_down_entry_control.sv ----
// Purpose: Power-down entry decision including quasi-idle defect path
// Assumes: Power-down instruction arrives as a one-cycle execute pulse
// Notes:   Quasi-idle is left only by NMI low or by reset
//
// Functional notes
// - Select clear, NMI high: instruction ignored
// - Select set, active wake pin: instruction ignored
// - Otherwise the instruction enters power-down
// - External fetch, mux wait zero: quasi-idle
// - Prior external write, external fetch: quasi-idle
// - Quasi-idle keeps peripherals and watchdog running
// - Quasi-idle blocks interrupts and event transfers
// - Quasi-idle enters power-down when NMI low
`default_nettype none
module power_down_entry_control
  import pd_entry_pkg::*;
#(
  parameter int N = WAKE_PINS_DEFAULT
) (
  // Clock and reset
  input  wire logic         i_sys_clk,
  input  wire logic         i_nrst,
  // Instruction stream
  input  wire logic         i_power_down_instruction,
  input  wire logic         i_next_fetch_external,
  input  wire logic         i_prev_external_write,
  input  wire logic         i_mux_bus,
  input  wire logic         i_mux_tristate_wait_bit,
  // Configuration
  input  wire logic         i_wake_source_select,
  input  wire logic [N-1:0] i_wake_enable,
  input  wire logic [N-1:0] i_wake_polarity,
  // Pins
  input  wire logic         i_nmi_pin,
  input  wire logic [N-1:0] i_wake_pin,
  // Status
  output logic              o_power_down,
  output logic              o_quasi_idle,
  output logic              o_cpu_fetch_enable,
  output logic              o_irq_service_enable,
  output logic              o_peripheral_event_transfer_enable,
  output logic              o_peripheral_clock_enable,
  output logic              o_instr_ignored
);
  pd_wake_if    wake ();
  pd_state_type state;
  pd_state_type next_state;
  logic         defect_lock;
  logic         next_ignored;

  // ****************************************************************
  // Wake source evaluation
  // ****************************************************************
  // the select bit in force at execute time picks the source
  assign wake.wake_select = i_wake_source_select;

  pd_wake_eval #(.N(N)) u_eval (
    .i_wake_pin      (i_wake_pin),
    .i_wake_enable   (i_wake_enable),
    .i_wake_polarity (i_wake_polarity),
    .i_nmi_pin       (i_nmi_pin),
    .wake            (wake)
  );

  // ****************************************************************
  // Defect detection
  // ****************************************************************
  // Defect path: fetch stalls instead of dropping the instruction.
  // Both terms need the code after the instruction to be external.
  assign defect_lock = i_next_fetch_external &&
    ((i_mux_bus && i_mux_tristate_wait_bit == MUX_WAIT_ACTIVE)
     || i_prev_external_write);

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  // Wake test comes first: with no wake source the entry is clean,
  // even when a defect term is set
  always_comb begin
    next_state   = state;
    next_ignored = 1'b0;
    unique case (state)
      ST_RUN: begin
        if (i_power_down_instruction) begin
          if (!wake.wake_active) begin
            next_state = ST_PDOWN;
          end else if (defect_lock) begin
            next_state = ST_QIDLE;
          end else begin
            next_ignored = 1'b1;
          end
        end
      end
      ST_QIDLE: begin
        if (!i_nmi_pin) begin
          next_state = ST_PDOWN;
        end
      end
      ST_PDOWN: begin
        next_state = ST_PDOWN;
      end
      default: begin
        next_state = ST_RUN;
      end
    endcase
  end

  // ****************************************************************
  // State registers
  // ****************************************************************
  // Power-down is left only by reset; wake sequencing lives elsewhere
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state <= ST_RUN;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_instr_ignored <= 1'b0;
    end else begin
      o_instr_ignored <= next_ignored;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign o_power_down       = (state == ST_PDOWN);
  assign o_quasi_idle       = (state == ST_QIDLE);
  assign o_cpu_fetch_enable = (state == ST_RUN);
  // Watchdog and peripherals keep clocking while quasi-idle
  assign o_peripheral_clock_enable = (state != ST_PDOWN);
  assign o_irq_service_enable      = (state == ST_RUN);
  assign o_peripheral_event_transfer_enable = (state == ST_RUN);

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb_sys @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_nrst);

  // Reference terms rebuilt from the pins, so a broken evaluator or
  // defect decode cannot hide behind its own output
  logic port_wake_seen;
  logic wake_seen;
  logic lock_seen;
  logic pd_exec;

  assign port_wake_seen = |((i_wake_pin ~^ i_wake_polarity)
                            & i_wake_enable);
  assign wake_seen      = (i_wake_source_select == SEL_PORT) ? port_wake_seen
                                                             : i_nmi_pin;
  assign lock_seen      = i_next_fetch_external
                          && ((i_mux_bus
                               && i_mux_tristate_wait_bit == MUX_WAIT_ACTIVE)
                              || i_prev_external_write);
  assign pd_exec        = (state == ST_RUN) && i_power_down_instruction;

  a_nmi_high_ignore: assert property (
    (pd_exec && i_wake_source_select == SEL_NMI && i_nmi_pin && !lock_seen)
    |=> (state == ST_RUN && o_instr_ignored))
    else $error("instruction not ignored with NMI high");
  a_port_wake_ignore: assert property (
    (pd_exec && i_wake_source_select == SEL_PORT && port_wake_seen
     && !lock_seen)
    |=> (!o_power_down && o_instr_ignored))
    else $error("entered power-down with wake pin active");

  a_entry_ok: assert property (
    (pd_exec && !wake_seen) |=> (o_power_down && !o_quasi_idle))
    else $error("power-down not entered");
  a_select_sampled: assert property (
    (pd_exec && i_wake_source_select == SEL_PORT && !port_wake_seen
     && i_nmi_pin) |=> o_power_down)
    else $error("select bit did not pick the port pins");
  a_pdown_sticky: assert property (
    o_power_down |=> o_power_down)
    else $error("power-down left without reset");
  a_ignore_only_run: assert property (
    (state != ST_RUN) |=> !o_instr_ignored)
    else $error("ignored pulse outside run");

  a_mux_lock: assert property (
    (pd_exec && wake_seen && i_next_fetch_external && i_mux_bus
     && i_mux_tristate_wait_bit == MUX_WAIT_ACTIVE)
    |=> (o_quasi_idle && !o_cpu_fetch_enable))
    else $error("mux wait defect not reproduced");
  a_write_lock: assert property (
    (pd_exec && wake_seen && i_next_fetch_external && i_prev_external_write)
    |=> (o_quasi_idle && !o_cpu_fetch_enable))
    else $error("prior write defect not reproduced");

  // Quasi-idle only stops the core; the watchdog must still bite
  a_qidle_periph: assert property (
    o_quasi_idle |-> o_peripheral_clock_enable)
    else $error("peripherals stopped in quasi-idle");
  a_qidle_noirq: assert property (
    o_quasi_idle |-> (!o_irq_service_enable
                      && !o_peripheral_event_transfer_enable))
    else $error("service enabled in quasi-idle");

  a_qidle_exit: assert property (
    (o_quasi_idle && !i_nmi_pin) |=> (o_power_down && !o_quasi_idle))
    else $error("NMI low did not enter power-down");
  a_qidle_hold: assert property (
    (o_quasi_idle && i_nmi_pin) |=> o_quasi_idle)
    else $error("quasi-idle left without NMI low");

  c_ignored:     cover property (o_instr_ignored);
  c_port_ignore: cover property (
    o_instr_ignored && $past(i_wake_source_select) == SEL_PORT);
  c_pdown:       cover property (
    $rose(o_power_down) && $past(state) == ST_RUN);
  c_qidle:       cover property ($rose(o_quasi_idle));
  c_qidle_pd:    cover property (o_quasi_idle ##1 o_power_down);
endmodule
`default_nettype wire

// ---- core/pd_entry_pkg.sv ----
// Purpose: Shared constants and types for power-down entry control
// Assumes: Single clock domain, asynchronous active-low reset
// Notes:   Wake pin count is a module parameter at the top
`default_nettype none
package pd_entry_pkg;
  localparam int          WAKE_PINS_DEFAULT = 4;
  localparam logic        SEL_NMI           = 1'b0;
  localparam logic        SEL_PORT          = 1'b1;
  localparam logic        MUX_WAIT_ACTIVE   = 1'b0;
  typedef enum logic [1:0] {
    ST_RUN   = 2'h0,
    ST_QIDLE = 2'h1,
    ST_PDOWN = 2'h3
  } pd_state_type;
endpackage
`default_nettype wire

// ---- core/pd_wake_if.sv ----
// Purpose: Carries the wake-condition verdict between block modules
// Assumes: Verdict driven by the wake evaluator, select driven by the top
// Notes:   Purely combinational signals
`default_nettype none
interface pd_wake_if;
  logic wake_select;
  logic wake_active;
  modport eval (input wake_select, output wake_active);
  modport ctrl (output wake_select, input wake_active);
endinterface
`default_nettype wire

// ---- core/pd_wake_eval.sv ----
// Purpose: Decides whether a wake source holds the device awake
// Assumes: Pin levels synchronous to the system clock
// Notes:   Port wake pins are active high after polarity adjust
`default_nettype none
module pd_wake_eval
  import pd_entry_pkg::*;
#(
  parameter int N = WAKE_PINS_DEFAULT
) (
  // Pins
  input  wire logic [N-1:0] i_wake_pin,
  input  wire logic [N-1:0] i_wake_enable,
  input  wire logic [N-1:0] i_wake_polarity,
  input  wire logic         i_nmi_pin,
  // Verdict
  pd_wake_if.eval           wake
);
  logic [N-1:0] pin_active;

  assign pin_active = (i_wake_pin ~^ i_wake_polarity) & i_wake_enable;

  // Selected source: high NMI level, or any enabled port pin active
  assign wake.wake_active = (wake.wake_select == SEL_NMI) ? i_nmi_pin
                                                          : |pin_active;
endmodule
`default_nettype wire

// ---- tb/wake_src_model.sv ----
// Purpose: Far-side model of the NMI pin and the port wake pins
// Assumes: Levels are requested by the bench just after a clock edge
// Notes:   Pins are always driven, so no released level is modelled
`default_nettype none
module wake_src_model #(
  parameter int N = 4
) (
  // Requested levels
  input  wire logic         i_nmi_level,
  input  wire logic [N-1:0] i_wake_level,
  // Pins
  output logic              o_nmi_pin,
  output logic [N-1:0]      o_wake_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // Driven without delay so the bench alone decides the sampling edge
  assign o_nmi_pin  = i_nmi_level;
  assign o_wake_pin = i_wake_level;
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
// Purpose: Self-checking bench for power-down entry control
// Assumes: Inputs change 1 ns after the rising clock edge
// Notes:   Each trial ends with a reset so every trial starts in run
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import pd_entry_pkg::*;
  logic         clk, nrst, instr, next_ext, prev_wr, mux, mtt, sel;
  logic         nmi_lvl, nmi, pd, qi, fe, ie, pe, ce, ign, run;
  logic [3:0]   en, pol, wake_lvl, wpin;
  logic [31:0]  r;
  integer       seed = 32'hc0c3;
  int           n_fail = 0;
  int           checks = 0;
  pd_state_type exp;
  wake_src_model #(.N(4)) i_pins (.i_nmi_level(nmi_lvl),
    .i_wake_level(wake_lvl), .o_nmi_pin(nmi), .o_wake_pin(wpin));
  power_down_entry_control #(.N(4)) i_dut (.i_sys_clk(clk), .i_nrst(nrst),
    .i_power_down_instruction(instr), .i_next_fetch_external(next_ext),
    .i_prev_external_write(prev_wr), .i_mux_bus(mux),
    .i_mux_tristate_wait_bit(mtt), .i_wake_source_select(sel),
    .i_wake_enable(en), .i_wake_polarity(pol), .i_nmi_pin(nmi),
    .i_wake_pin(wpin), .o_power_down(pd), .o_quasi_idle(qi),
    .o_cpu_fetch_enable(fe), .o_irq_service_enable(ie),
    .o_peripheral_event_transfer_enable(pe),
    .o_peripheral_clock_enable(ce), .o_instr_ignored(ign));
  task automatic tally_and_finish();
    if (n_fail == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic seen, input logic want);
    checks++;
    if (seen !== want) begin
      n_fail++;
      $display("CHECK FAILED %0t output differs from prediction", $time);
    end
  endtask
  task automatic check_state(input pd_state_type s);
    chk(pd, s == ST_PDOWN);
    chk(qi, s == ST_QIDLE);
    chk(fe, s == ST_RUN);
    chk(ie, s == ST_RUN);
    chk(pe, s == ST_RUN);
    chk(ce, s != ST_PDOWN);
  endtask
  task automatic step();
    @(posedge clk);
    #1;
  endtask
  // Wake test outranks the defect path: no wake source, clean entry
  function automatic pd_state_type predict();
    logic wake;
    wake = (sel == SEL_PORT) ? |(en & ~(wake_lvl ^ pol)) : nmi_lvl;
    if (!wake) return ST_PDOWN;
    if (next_ext && ((mux && mtt == MUX_WAIT_ACTIVE) || prev_wr))
      return ST_QIDLE;
    return ST_RUN;
  endfunction
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    #20000;
    n_fail++;
    tally_and_finish();
  end
  // ****************************************************************
  // Main sequence: random trials with hand-set corner cases first
  // ****************************************************************
  initial begin
    {instr, next_ext, prev_wr, mux, mtt, sel, nmi_lvl} = '0;
    {en, pol, wake_lvl} = '0;
    nrst = 1'b0;
    repeat (3) @(posedge clk);
    #1 nrst = 1'b1;
    for (int i = 0; i < 80; i++) begin
      r = $random(seed);
      // Corners first, bit order as unpacked below:
      // next_ext, prev_wr, mux, mtt, sel, nmi_lvl
      case (i)
        0: r[5:0] = 6'h30;
        1: r[5:0] = 6'h31;
        2: r[5:0] = 6'h09;
        3: r[5:0] = 6'h21;
        4: r[5:0] = 6'h29;
        5: r[17:0] = 18'h3FC42;
        default: ;
      endcase
      {next_ext, prev_wr, mux, mtt, sel, nmi_lvl} = r[5:0];
      {en, pol, wake_lvl} = r[17:6];
      exp = predict();
      instr = 1'b1;
      step();
      check_state(exp);
      chk(ign, exp == ST_RUN);
      // Instruction held for a second try: only run takes it, and the
      // select in force at that edge decides
      run = (exp == ST_RUN);
      sel = ~sel;
      if (exp == ST_QIDLE) nmi_lvl = 1'b1;
      if (run) exp = predict();
      step();
      instr = 1'b0;
      check_state(exp);
      chk(ign, run && exp == ST_RUN);
      if (exp == ST_QIDLE) begin
        nmi_lvl = 1'b0;
        step();
        check_state(ST_PDOWN);
      end
      nrst = 1'b0;
      #1;
      check_state(ST_RUN);
      chk(ign, 1'b0);
      step();
      nrst = 1'b1;
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
